// [rtl/poh_pkg.sv]
package poh_pkg;

  // line byte clock and the port clock derived from it
  localparam int LINE_CLK_KHZ = 19440;
  localparam int PORT_CLK_KHZ = 2160;
  localparam int PORT_AVG_KHZ = 576;
  localparam int FRAME_US = 125;

  // line clock cycles per port clock slot, and how many of them are high
  localparam int PHASES = LINE_CLK_KHZ / PORT_CLK_KHZ;
  localparam int HIGH_PHASES = 4;
  // the serial input is taken this many cycles into a slot
  localparam int CAPTURE_PHASE = 2;

  // pulses are spread as 4 out of every 15 slots (2.16 MHz -> 576 kHz)
  localparam int GROUP_SLOTS = 15;
  localparam int GROUP_PULSES = 4;
  localparam int BITS_PER_FRAME = PORT_AVG_KHZ * FRAME_US / 1000;

  // path overhead byte order on the serial port
  typedef logic [3:0] poh_idx_t;
  localparam poh_idx_t IDX_J1 = 4'h0;
  localparam poh_idx_t IDX_B3 = 4'h1;
  localparam poh_idx_t IDX_C2 = 4'h2;
  localparam poh_idx_t IDX_G1 = 4'h3;
  localparam poh_idx_t IDX_F2 = 4'h4;
  localparam poh_idx_t IDX_H4 = 4'h5;
  localparam poh_idx_t IDX_Z3 = 4'h6;
  localparam poh_idx_t IDX_Z4 = 4'h7;
  localparam poh_idx_t IDX_Z5 = 4'h8;
  localparam poh_idx_t IDX_NONE = 4'hf;
  localparam int POH_BYTES = 9;

  // crossing word: {index, enable byte, data byte}
  localparam int WORD_W = 20;
  localparam int FIFO_DEPTH = 16;
  localparam int STALL_LEVEL = FIFO_DEPTH - 2;

  // reset values
  localparam logic PORT_CLK_RST = 1'b0;
  localparam logic FRAME_POS_RST = 1'b1;

  function automatic logic poh_is_mask(input poh_idx_t idx);
    return (idx == IDX_B3) || (idx == IDX_H4);
  endfunction : poh_is_mask

  function automatic logic poh_is_overhead(input poh_idx_t idx);
    return idx < poh_idx_t'(POH_BYTES);
  endfunction : poh_is_overhead

endpackage : poh_pkg

// [rtl/poh_fifo.sv]
`timescale 1ns/10ps
module poh_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  // occupancy
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [$clog2(DEPTH+1)-1:0] count_q;
  logic do_wr;
  logic do_rd;

  assign in_ready = count_q != ($clog2(DEPTH+1))'(DEPTH);
  assign out_valid = count_q != '0;
  assign out_data = mem_q[rd_ptr_q];
  assign level = count_q;
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (do_wr)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (do_wr && !do_rd)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule : poh_fifo

// [rtl/poh_insert_port.sv]
`timescale 1ns/10ps
module poh_insert_port
  import poh_pkg::*;
#(
  parameter int FIFO_W = WORD_W,
  parameter int FIFO_D = FIFO_DEPTH
) (
  // system side clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // transmit line byte clock, clocks the port logic
  input wire logic tx_line_byte_clk,
  // serial path overhead port
  input wire logic path_ovh_serial_in,
  input wire logic path_ovh_insert_en,
  output logic path_ovh_port_clk,
  output logic path_ovh_frame_pos,
  // transmit byte stream in, tagged with its overhead position
  input wire logic [7:0] tx_in_data,
  input wire logic [3:0] tx_in_poh_idx,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  // merged transmit byte stream out
  output logic [7:0] tx_parallel_stream,
  output logic tx_out_valid,
  output logic tx_poh_slip
);

  // ---------------- port side, line byte clock ----------------
  logic link_rst_s1_q;
  logic link_rstn_q;
  logic ser_s1_q;
  logic ser_s2_q;
  logic en_s1_q;
  logic en_s2_q;
  logic stall_s1_q;
  logic stall_s2_q;
  logic [3:0] phase_q;
  logic [3:0] grp_q;
  logic [6:0] bit_q;
  logic [7:0] sh_data_q;
  logic [7:0] sh_en_q;
  logic [WORD_W-1:0] word_q;
  logic xfer_tgl_q;
  logic port_clk_q;
  logic frame_pos_q;
  logic pulse;
  logic freeze;
  logic cap;

  // ---------------- system side, ref_clk ----------------
  logic xfer_s1_q;
  logic xfer_s2_q;
  logic xfer_s3_q;
  logic stall_q;
  logic push;
  logic fifo_in_ready;
  logic [FIFO_W-1:0] fifo_out;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [$clog2(FIFO_D+1)-1:0] fifo_level;
  poh_idx_t head_idx;
  logic [7:0] head_en;
  logic [7:0] head_data;
  logic hold_v_q;
  logic [7:0] hold_data_q;
  poh_idx_t hold_idx_q;
  logic hold_poh;
  logic match;
  logic resolve;
  logic discard;
  logic accept;
  logic [7:0] merged;
  logic ready_q;
  logic [7:0] stream_q;
  logic out_valid_q;
  logic slip_q;

  // reset reaches the port side through two flops
  always_ff @(posedge tx_line_byte_clk)
  begin
    link_rst_s1_q <= resetn;
    link_rstn_q <= link_rst_s1_q;
  end

  // pins and the stall level are foreign to this clock
  always_ff @(posedge tx_line_byte_clk)
  begin
    ser_s1_q <= path_ovh_serial_in;
    ser_s2_q <= ser_s1_q;
    en_s1_q <= path_ovh_insert_en;
    en_s2_q <= en_s1_q;
    stall_s1_q <= stall_q;
    stall_s2_q <= stall_s1_q;
  end

  assign pulse = grp_q < 4'(GROUP_PULSES);
  // a stall only ever holds a pulse back before it starts
  assign freeze = stall_s2_q && pulse && (phase_q == '0);
  assign cap = pulse && (phase_q == 4'(CAPTURE_PHASE));

  always_ff @(posedge tx_line_byte_clk)
  begin
    if (!link_rstn_q)
    begin
      phase_q <= '0;
      grp_q <= '0;
    end
    else if (!freeze)
    begin
      phase_q <= (phase_q == 4'(PHASES - 1)) ? '0 : phase_q + 1'b1;
      if (phase_q == 4'(PHASES - 1))
      begin
        grp_q <= (grp_q == 4'(GROUP_SLOTS - 1)) ? '0 : grp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge tx_line_byte_clk)
  begin
    if (!link_rstn_q)
    begin
      bit_q <= '0;
    end
    else if (cap)
    begin
      bit_q <= (bit_q == 7'(BITS_PER_FRAME - 1)) ? '0 : bit_q + 1'b1;
    end
  end

  // the synchronised pin is taken two cycles after the port clock rises
  always_ff @(posedge tx_line_byte_clk)
  begin
    if (!link_rstn_q)
    begin
      sh_data_q <= '0;
      sh_en_q <= '0;
    end
    else if (cap)
    begin
      sh_data_q <= {sh_data_q[6:0], ser_s2_q};
      sh_en_q <= {sh_en_q[6:0], en_s2_q};
    end
  end

  // a full byte is held steady for 8 pulses, so a toggle is enough
  always_ff @(posedge tx_line_byte_clk)
  begin
    if (!link_rstn_q)
    begin
      word_q <= '0;
      xfer_tgl_q <= 1'b0;
    end
    else if (cap && (bit_q[2:0] == 3'h7))
    begin
      word_q <= {bit_q[6:3], sh_en_q[6:0], en_s2_q,
                 sh_data_q[6:0], ser_s2_q};
      xfer_tgl_q <= ~xfer_tgl_q;
    end
  end

  // port clock and frame marker move on the falling line clock edge
  always_ff @(negedge tx_line_byte_clk)
  begin
    if (!link_rstn_q)
    begin
      port_clk_q <= PORT_CLK_RST;
      frame_pos_q <= FRAME_POS_RST;
    end
    else
    begin
      port_clk_q <= pulse && (phase_q < 4'(HIGH_PHASES)) && !freeze;
      if (pulse && (phase_q == 4'(HIGH_PHASES)))
      begin
        frame_pos_q <= (bit_q == '0);
      end
    end
  end

  assign path_ovh_port_clk = port_clk_q;
  assign path_ovh_frame_pos = frame_pos_q;

  // ---------------- crossing into ref_clk ----------------
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      xfer_s1_q <= 1'b0;
      xfer_s2_q <= 1'b0;
      xfer_s3_q <= 1'b0;
    end
    else
    begin
      xfer_s1_q <= xfer_tgl_q;
      xfer_s2_q <= xfer_s1_q;
      xfer_s3_q <= xfer_s2_q;
    end
  end

  assign push = xfer_s2_q ^ xfer_s3_q;

  // stalls the port clock early enough that the words in flight still fit
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      stall_q <= 1'b0;
    end
    else
    begin
      stall_q <= (fifo_level >= ($clog2(FIFO_D+1))'(STALL_LEVEL))
                 || !fifo_in_ready;
    end
  end

  poh_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .clk(ref_clk),
    .resetn(resetn),
    .in_data(word_q),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .level(fifo_level)
  );

  // ---------------- merge into the byte stream ----------------
  assign head_idx = fifo_out[19:16];
  assign head_en = fifo_out[15:8];
  assign head_data = fifo_out[7:0];
  assign hold_poh = poh_is_overhead(hold_idx_q);
  assign match = fifo_out_valid && (head_idx == hold_idx_q);
  assign resolve = hold_v_q && (!hold_poh || match);
  // a stale head word is dropped to get back in step
  assign discard = hold_v_q && hold_poh && fifo_out_valid && !match;
  assign fifo_pop = hold_v_q && hold_poh && fifo_out_valid;
  assign accept = tx_in_valid && ready_q;

  always_comb
  begin
    if (!hold_poh)
    begin
      merged = hold_data_q;
    end
    else if (poh_is_mask(hold_idx_q))
    begin
      merged = hold_data_q ^ (head_en & head_data);
    end
    else
    begin
      merged = (head_en & head_data)
             | (~head_en & hold_data_q);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      hold_v_q <= 1'b0;
      hold_data_q <= '0;
      hold_idx_q <= IDX_NONE;
    end
    else if (accept)
    begin
      hold_v_q <= 1'b1;
      hold_data_q <= tx_in_data;
      hold_idx_q <= tx_in_poh_idx;
    end
    else if (resolve)
    begin
      hold_v_q <= 1'b0;
    end
  end

  // one byte in hold at a time: half rate, but ready stays registered
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      ready_q <= 1'b0;
    end
    else
    begin
      ready_q <= !(accept || (hold_v_q && !resolve));
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      stream_q <= '0;
      out_valid_q <= 1'b0;
      slip_q <= 1'b0;
    end
    else
    begin
      out_valid_q <= resolve;
      slip_q <= discard;
      if (resolve)
      begin
        stream_q <= merged;
      end
    end
  end

  assign tx_in_ready = ready_q;
  assign tx_parallel_stream = stream_q;
  assign tx_out_valid = out_valid_q;
  assign tx_poh_slip = slip_q;

  // ---------------- checks ----------------
  port_high_len_a: assert property (@(posedge tx_line_byte_clk)
    disable iff (!link_rstn_q)
    $rose(port_clk_q) |-> port_clk_q [*4] ##1 !port_clk_q)
    else $error("port clock high time is not four line cycles");

  port_low_len_a: assert property (@(posedge tx_line_byte_clk)
    disable iff (!link_rstn_q)
    $fell(port_clk_q) |-> !port_clk_q [*5])
    else $error("port clock low time is under five line cycles");

  data_capture_a: assert property (@(posedge tx_line_byte_clk)
    disable iff (!link_rstn_q)
    $rose(port_clk_q) ##2 cap |=> sh_data_q[0] == $past(ser_s2_q))
    else $error("serial bit not taken after port clock rise");

  enable_capture_a: assert property (@(posedge tx_line_byte_clk)
    disable iff (!link_rstn_q)
    $rose(port_clk_q) ##2 cap |=> sh_en_q[0] == $past(en_s2_q))
    else $error("insert enable not taken after port clock rise");

  frame_mark_a: assert property (@(posedge tx_line_byte_clk)
    disable iff (!link_rstn_q)
    $rose(port_clk_q) |-> frame_pos_q == (bit_q == '0))
    else $error("frame position does not mark the first J1 bit");

  frame_edge_a: assert property (@(posedge tx_line_byte_clk)
    disable iff (!link_rstn_q)
    $changed(frame_pos_q) |-> $fell(port_clk_q))
    else $error("frame position moved away from a port clock fall");

  insert_bits_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    resolve && hold_poh && !poh_is_mask(hold_idx_q) |=>
      ((stream_q ^ $past(head_data)) & $past(head_en)) == 8'h00)
    else $error("enabled serial bits not placed in the stream");

  keep_bits_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    resolve && hold_poh && !poh_is_mask(hold_idx_q) |=>
      ((stream_q ^ $past(hold_data_q)) & ~$past(head_en)) == 8'h00)
    else $error("unenabled bits not taken from the internal byte");

  error_mask_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    resolve && poh_is_mask(hold_idx_q) |=> tx_out_valid &&
      stream_q == ($past(hold_data_q) ^ ($past(head_en) & $past(head_data))))
    else $error("B3 or H4 error mask applied wrongly");

endmodule : poh_insert_port

// [tb/poh_upstream_model.sv]
`timescale 1ns/10ps
module poh_upstream_model (
  // port from the device
  input wire logic path_ovh_port_clk,
  input wire logic path_ovh_frame_pos,
  // bits to send, first bit on top
  input wire logic [71:0] data_bits,
  input wire logic [71:0] en_bits,
  // serial lines to the device
  output logic path_ovh_serial_in,
  output logic path_ovh_insert_en
);
  int cnt = 0;
  // lines move just after each port clock fall
  always @(negedge path_ovh_port_clk)
  begin
    #1;
    cnt = path_ovh_frame_pos ? 0 : (cnt + 1) % 72;
  end
  assign path_ovh_serial_in = data_bits[71 - cnt];
  assign path_ovh_insert_en = en_bits[71 - cnt];
endmodule : poh_upstream_model

// [tb/tb_path_overhead_insert_port.sv]
`timescale 1ns/10ps
module tb_path_overhead_insert_port;
  import poh_pkg::*;
  logic ref_clk = 1'b0;
  logic tx_line_byte_clk = 1'b0;
  logic resetn = 1'b0;
  logic path_ovh_serial_in, path_ovh_insert_en;
  logic path_ovh_port_clk, path_ovh_frame_pos;
  logic [7:0] tx_in_data = 8'h00;
  logic [3:0] tx_in_poh_idx = 4'h0;
  logic tx_in_valid = 1'b0;
  logic tx_in_ready, tx_out_valid, tx_poh_slip;
  logic [7:0] tx_parallel_stream;
  logic [71:0] data_bits, en_bits;
  logic [15:0] rnd = 16'h503a;
  int fails = 0;
  int total_checks = 0;
  int slips = 0;
  int gap = 0;
  int pulses = 0;
  realtime t_rise;

  initial forever #20 ref_clk = ~ref_clk;
  initial
  begin
    #7;
    forever #15 tx_line_byte_clk = ~tx_line_byte_clk;
  end

  poh_insert_port poh_insert_port_inst (
    .ref_clk(ref_clk), .resetn(resetn),
    .tx_line_byte_clk(tx_line_byte_clk),
    .path_ovh_serial_in(path_ovh_serial_in),
    .path_ovh_insert_en(path_ovh_insert_en),
    .path_ovh_port_clk(path_ovh_port_clk),
    .path_ovh_frame_pos(path_ovh_frame_pos),
    .tx_in_data(tx_in_data), .tx_in_poh_idx(tx_in_poh_idx),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
    .tx_parallel_stream(tx_parallel_stream),
    .tx_out_valid(tx_out_valid), .tx_poh_slip(tx_poh_slip)
  );

  poh_upstream_model poh_upstream_model_inst (
    .path_ovh_port_clk(path_ovh_port_clk),
    .path_ovh_frame_pos(path_ovh_frame_pos),
    .data_bits(data_bits), .en_bits(en_bits),
    .path_ovh_serial_in(path_ovh_serial_in),
    .path_ovh_insert_en(path_ovh_insert_en)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  function automatic logic [7:0] merged(input logic [7:0] d,
                                        input logic [3:0] i);
    logic [7:0] s;
    logic [7:0] e;
    if (i > 4'h8)
      return d;
    s = data_bits[71 - 8 * i -: 8];
    e = en_bits[71 - 8 * i -: 8];
    if (i == 4'h1 || i == 4'h5)
      return d ^ (e & s);
    return (e & s) | (~e & d);
  endfunction : merged

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic send(input logic [7:0] d, input logic [3:0] i);
    int n;
    @(posedge ref_clk);
    tx_in_data <= d;
    tx_in_poh_idx <= i;
    tx_in_valid <= 1'b1;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end while (tx_in_ready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fails++;
      end_sim();
    end
    @(posedge ref_clk);
    tx_in_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end while (tx_out_valid !== 1'b1 && n < 5000);
    if (n >= 5000)
    begin
      fails++;
      end_sim();
    end
    chk("stream", merged(d, i), tx_parallel_stream);
    // take edge sets the hold, the next edge launches the merged byte
    if (i > 4'h8)
      chk("latency", 8'h02, 8'(n));
  endtask : send

  // port clock may only move on a line clock fall
  always @(path_ovh_port_clk)
    if (resetn)
      chk("port clk edge", 8'h00, {7'h0, tx_line_byte_clk});
  always @(posedge path_ovh_port_clk)
  begin
    t_rise = $realtime;
    pulses++;
    if (path_ovh_frame_pos === 1'b1)
    begin
      if (gap > 0)
        chk("frame bits", 8'(POH_BYTES * 8), 8'(gap));
      gap = 0;
    end
    gap++;
  end
  always @(negedge path_ovh_port_clk)
    if (resetn)
      chk("high time", 8'h04, 8'(int'(($realtime - t_rise) / 30)));
  // delayed look so a same-edge port clock fall has landed
  always @(path_ovh_frame_pos)
    if (resetn)
    begin
      #1;
      chk("frame pos edge", 8'h00, {7'h0, path_ovh_port_clk});
    end
  always @(negedge ref_clk)
    if (tx_poh_slip === 1'b1)
      slips++;

  initial
  begin
    for (int k = 0; k < 9; k++)
    begin
      rnd = lfsr(rnd);
      data_bits[8 * k +: 8] = rnd[7:0];
      rnd = lfsr(rnd);
      en_bits[8 * k +: 8] = rnd[7:0];
    end
    // full mask on one error byte, none on the other
    en_bits[63:56] = 8'hff;
    en_bits[31:24] = 8'h00;
    repeat (6) @(posedge ref_clk);
    chk("frame pos rst", 8'h01, {7'h0, path_ovh_frame_pos});
    resetn <= 1'b1;
    // idle long enough for the buffer to fill and stall the port
    repeat (4000) @(posedge ref_clk);
    chk("stall", 8'h01, {7'h0, pulses >= 112 && pulses <= 129});
    for (int f = 0; f < 5; f++)
      for (int i = 0; i < 9; i++)
      begin
        rnd = lfsr(rnd);
        send(rnd[15:8], 4'h9 + 4'(rnd[2:0] % 7));
        rnd = lfsr(rnd);
        if (f != 3 || (i != 3 && i != 4))
          send(rnd[7:0], 4'(i));
      end
    chk("slips", 8'h02, 8'(slips));
    end_sim();
  end
endmodule : tb_path_overhead_insert_port
